// [common/token_net_map.svh]
// Offsets, field positions, reset values and timing counts of the reset and diagnostics block.
`ifndef TOKEN_NET_MAP_SVH
`define TOKEN_NET_MAP_SVH
`define CFG_SW_RESET_BIT 7
`define CFG_JOIN_EN_BIT 5
`define CFG_SCALE_A_BIT 3
`define CFG_SCALE_B_BIT 4
`define AUX_SHORT_REFUSAL_BIT 0
`define CFG_RESET_VAL 8'h00
`define AUX_RESET_VAL 8'h00
`define SIG_PATTERN 8'hD1
`define SIG_ADDR_PATTERN 11'h000
`define SIG_ADDR_IDENT 11'h001
`define RST_FILTER_PERIODS 5
`define REFUSAL_LONG_LIMIT 128
`define REFUSAL_SHORT_LIMIT 4
`define CLK_KHZ 10000
`define DUP_WIN_SHORT_MS 420
`define DUP_WIN_LONG_MS 840
`endif

// [common/token_net_pkg.sv]
// Types shared by the reset and diagnostics block.
package token_net_pkg;
   typedef enum logic [1:0] {
      SIG_IDLE = 2'b00,
      SIG_PATTERN_WR = 2'b01,
      SIG_IDENT_WR = 2'b10
   } sig_state_t;
   typedef struct packed {
      logic token_valid;
      logic [7:0] token_dest;
      logic token_from_self;
      logic response_seen;
      logic reshuffle_timer_expired;
      logic nak_rx;
      logic token_rx;
      logic [7:0] next_node;
   } net_events_t;
   typedef struct packed {
      logic dup_node_flag;
      logic self_caused_reshuffle_flag;
      logic line_activity_flag;
      logic token_seen_flag;
      logic refusal_limit_flag;
      logic probe_match_flag;
      logic new_next_node_flag;
      logic tx_available_flag;
   } diag_flags_t;
   typedef struct packed {
      logic we;
      logic [10:0] addr;
      logic [7:0] data;
   } ram_wr_t;
endpackage

// [hdl/token_net_reset_init_diag.sv]
// Reset handling, node start-up and network diagnostics of the token network controller.
`timescale 1ns/10ps
`include "token_net_map.svh"
module token_net_reset_init_diag
   import token_net_pkg::*;
#(
   parameter int DUP_WIN_SHORT_CYC = `DUP_WIN_SHORT_MS * `CLK_KHZ,
   parameter int DUP_WIN_LONG_CYC = `DUP_WIN_LONG_MS * `CLK_KHZ,
   parameter int FILTER_PERIODS = `RST_FILTER_PERIODS
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic hw_reset_in_n,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic aux_we,
   input wire logic [7:0] aux_wdata,
   input wire logic nid_we,
   input wire logic [7:0] nid_wdata,
   input wire logic tent_we,
   input wire logic [7:0] tent_wdata,
   input wire logic diag_rd,
   input wire logic clear_flags_cmd,
   input wire logic tx_enable_cmd,
   input wire logic tx_disable_cmd,
   input wire logic host_wr_odd,
   input wire logic host_rd_odd,
   input wire logic host_mode_in,
   input wire logic rx_line_in,
   input net_events_t net_ev,
   output logic [7:0] cfg_reg,
   output logic [7:0] aux_setup_reg,
   output logic [7:0] node_identity_reg,
   output diag_flags_t diag_flags,
   output logic refusal_irq,
   output ram_wr_t ram_wr,
   output logic core_awake,
   output logic join_active,
   output logic tx_driver_en,
   output logic bus_mode,
   output logic bus_mode_known,
   output logic dup_check_done,
   output logic in_reset
);

   // ************************************************************
   // Reset conditioning
   // ************************************************************
   logic [1:0] nrst_sync_ff;
   logic rst_n;
   logic hwr_meta_ff;
   logic hwr_sync_ff;
   logic [3:0] hwr_low_cnt_ff;
   logic hw_rst_ff;
   logic sw_rst;
   logic core_rst;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         nrst_sync_ff <= 2'h0;
      else
         nrst_sync_ff <= {nrst_sync_ff[0], 1'b1};
   end
   assign rst_n = nrst_sync_ff[1];

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hwr_meta_ff <= 1'b1;
         hwr_sync_ff <= 1'b1;
      end
      else
      begin
         hwr_meta_ff <= hw_reset_in_n;
         hwr_sync_ff <= hwr_meta_ff;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hwr_low_cnt_ff <= 4'h0;
         hw_rst_ff <= 1'b1;
      end
      else if (hwr_sync_ff)
      begin
         hwr_low_cnt_ff <= 4'h0;
         hw_rst_ff <= 1'b0;
      end
      else if (hwr_low_cnt_ff >= 4'(FILTER_PERIODS - 1))
         hw_rst_ff <= 1'b1;
      else
         hwr_low_cnt_ff <= hwr_low_cnt_ff + 4'h1;
   end

   assign sw_rst = cfg_reg[`CFG_SW_RESET_BIT];
   assign core_rst = hw_rst_ff | sw_rst;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         in_reset <= 1'b1;
      else
         in_reset <= core_rst;
   end

   // ************************************************************
   // Registers kept through software reset
   // ************************************************************
   // only hardware reset clears these
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_reg <= `CFG_RESET_VAL;
         aux_setup_reg <= `AUX_RESET_VAL;
      end
      else if (hw_rst_ff)
      begin
         cfg_reg <= `CFG_RESET_VAL;
         aux_setup_reg <= `AUX_RESET_VAL;
      end
      else
      begin
         if (cfg_we)
            cfg_reg <= cfg_wdata;
         if (aux_we)
            aux_setup_reg <= aux_wdata;
      end
   end

   // bus type from odd address access
   logic odd_wr_seen_ff;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         odd_wr_seen_ff <= 1'b0;
         bus_mode_known <= 1'b0;
         bus_mode <= 1'b0;
      end
      else if (hw_rst_ff)
      begin
         odd_wr_seen_ff <= 1'b0;
         bus_mode_known <= 1'b0;
         bus_mode <= 1'b0;
      end
      else if (!bus_mode_known)
      begin
         if (host_wr_odd)
            odd_wr_seen_ff <= 1'b1;
         if (odd_wr_seen_ff && host_rd_odd)
         begin
            bus_mode_known <= 1'b1;
            bus_mode <= host_mode_in;
         end
      end
   end

   // ************************************************************
   // Node identity, wake-up and signature
   // ************************************************************
   logic [7:0] tent_id_ff;
   logic awake;
   logic joined;
   sig_state_t sig_state_ff;

   // identity back to zero on any reset
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         node_identity_reg <= 8'h00;
         tent_id_ff <= 8'h00;
      end
      else if (core_rst)
      begin
         node_identity_reg <= 8'h00;
         tent_id_ff <= 8'h00;
      end
      else
      begin
         if (nid_we)
            node_identity_reg <= nid_wdata;
         if (tent_we)
            tent_id_ff <= tent_wdata;
      end
   end

   // core sleeps while identity is zero
   assign awake = (node_identity_reg != 8'h00);
   assign joined = awake && cfg_reg[`CFG_JOIN_EN_BIT];

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_awake <= 1'b0;
         join_active <= 1'b0;
         tx_driver_en <= 1'b0;
      end
      else
      begin
         core_awake <= awake && !core_rst;
         join_active <= joined && !core_rst;
         tx_driver_en <= joined && !core_rst;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sig_state_ff <= SIG_IDLE;
         ram_wr <= '0;
      end
      else if (core_rst)
      begin
         sig_state_ff <= SIG_IDLE;
         ram_wr <= '0;
      end
      else
      begin
         unique case (sig_state_ff)
            SIG_IDLE:
            begin
               ram_wr.we <= 1'b0;
               if (nid_we)
                  sig_state_ff <= SIG_PATTERN_WR;
            end
            SIG_PATTERN_WR:
            begin
               ram_wr <= '{we: 1'b1, addr: `SIG_ADDR_PATTERN, data: `SIG_PATTERN};
               sig_state_ff <= SIG_IDENT_WR;
            end
            SIG_IDENT_WR:
            begin
               ram_wr <= '{we: 1'b1, addr: `SIG_ADDR_IDENT, data: node_identity_reg};
               sig_state_ff <= SIG_IDLE;
            end
            default:
            begin
               ram_wr.we <= 1'b0;
               sig_state_ff <= SIG_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Duplicate identity and probe tracking
   // ************************************************************
   logic own_probe_ff;
   logic tent_probe_ff;
   logic dup_hit;
   logic tent_hit;
   logic [23:0] dup_win_cnt_ff;
   logic [23:0] dup_win_lim;

   // tokens to our identity awaiting an answer
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         own_probe_ff <= 1'b0;
         tent_probe_ff <= 1'b0;
      end
      else if (core_rst || !awake)
      begin
         own_probe_ff <= 1'b0;
         tent_probe_ff <= 1'b0;
      end
      else if (net_ev.token_valid && !net_ev.token_from_self)
      begin
         own_probe_ff <= (net_ev.token_dest == node_identity_reg);
         tent_probe_ff <= (tent_id_ff != 8'h00) && (net_ev.token_dest == tent_id_ff);
      end
   end
   assign dup_hit = own_probe_ff && net_ev.response_seen;
   assign tent_hit = tent_probe_ff && net_ev.response_seen;

   // detection window length from scale bits
   assign dup_win_lim = (cfg_reg[`CFG_SCALE_A_BIT] && cfg_reg[`CFG_SCALE_B_BIT]) ?
                        24'(DUP_WIN_SHORT_CYC) : 24'(DUP_WIN_LONG_CYC);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dup_win_cnt_ff <= 24'h000000;
         dup_check_done <= 1'b0;
      end
      else if (core_rst || nid_we || !awake)
      begin
         dup_win_cnt_ff <= 24'h000000;
         dup_check_done <= 1'b0;
      end
      else if (dup_win_cnt_ff >= dup_win_lim - 24'h000001)
         dup_check_done <= 1'b1;
      else
         dup_win_cnt_ff <= dup_win_cnt_ff + 24'h000001;
   end

   // ************************************************************
   // Refusal counting and transmitter availability
   // ************************************************************
   logic [6:0] refusal_cnt_ff;
   logic [6:0] refusal_last;
   logic refusal_hit;
   logic tx_cancel_ff;

   // wrapping counter, limit from aux setup
   assign refusal_last = aux_setup_reg[`AUX_SHORT_REFUSAL_BIT] ?
                         7'(`REFUSAL_SHORT_LIMIT - 1) : 7'(`REFUSAL_LONG_LIMIT - 1);
   assign refusal_hit = net_ev.nak_rx && (refusal_cnt_ff >= refusal_last);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         refusal_cnt_ff <= 7'h00;
      else if (core_rst)
         refusal_cnt_ff <= 7'h00;
      else if (refusal_hit)
         refusal_cnt_ff <= 7'h00;
      else if (net_ev.nak_rx)
         refusal_cnt_ff <= refusal_cnt_ff + 7'h01;
   end

   // ************************************************************
   // Diagnostic flags, set wins over clear; tent_we clears probe_match_flag over its set
   // ************************************************************
   logic [7:0] last_next_ff;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         last_next_ff <= 8'h00;
      else if (core_rst)
         last_next_ff <= 8'h00;
      else
         last_next_ff <= net_ev.next_node;
   end

   // All flag fields live in one process so the status word has a single driver.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_cancel_ff <= 1'b0;
         diag_flags.tx_available_flag <= 1'b1;
         diag_flags.dup_node_flag <= 1'b0;
         diag_flags.self_caused_reshuffle_flag <= 1'b0;
         diag_flags.line_activity_flag <= 1'b0;
         diag_flags.token_seen_flag <= 1'b0;
         diag_flags.refusal_limit_flag <= 1'b0;
         diag_flags.probe_match_flag <= 1'b0;
         diag_flags.new_next_node_flag <= 1'b0;
         refusal_irq <= 1'b0;
      end
      else if (core_rst)
      begin
         tx_cancel_ff <= 1'b0;
         diag_flags.tx_available_flag <= 1'b1;
         diag_flags.dup_node_flag <= 1'b0;
         diag_flags.self_caused_reshuffle_flag <= 1'b0;
         diag_flags.line_activity_flag <= 1'b0;
         diag_flags.token_seen_flag <= 1'b0;
         diag_flags.refusal_limit_flag <= 1'b0;
         diag_flags.probe_match_flag <= 1'b0;
         diag_flags.new_next_node_flag <= 1'b0;
         refusal_irq <= 1'b0;
      end
      else
      begin
         // abandon and free at next token
         if (tx_disable_cmd)
            tx_cancel_ff <= !diag_flags.tx_available_flag;
         else if (tx_cancel_ff && net_ev.token_rx)
         begin
            tx_cancel_ff <= 1'b0;
            diag_flags.tx_available_flag <= 1'b1;
         end
         else if (tx_enable_cmd)
            diag_flags.tx_available_flag <= 1'b0;
         diag_flags.dup_node_flag <= dup_hit || (diag_flags.dup_node_flag && !diag_rd);
         diag_flags.self_caused_reshuffle_flag <= (joined && net_ev.reshuffle_timer_expired) ||
            (diag_flags.self_caused_reshuffle_flag && !diag_rd);
         diag_flags.line_activity_flag <= rx_line_in ||
            (diag_flags.line_activity_flag && !clear_flags_cmd);
         diag_flags.token_seen_flag <= (net_ev.token_valid && !net_ev.token_from_self) ||
            (diag_flags.token_seen_flag && !clear_flags_cmd);
         diag_flags.refusal_limit_flag <= refusal_hit ||
            (diag_flags.refusal_limit_flag && !clear_flags_cmd);
         refusal_irq <= refusal_hit || (refusal_irq && !clear_flags_cmd);
         diag_flags.probe_match_flag <= (tent_hit && !tent_we) ||
            (diag_flags.probe_match_flag && !clear_flags_cmd && !tent_we);
         diag_flags.new_next_node_flag <= (awake && net_ev.next_node != last_next_ff) ||
            (diag_flags.new_next_node_flag && !clear_flags_cmd);
      end
   end

endmodule // token_net_reset_init_diag

// [dv/token_net_reset_init_diag_properties.sv]
// Port-level concurrent checks of the reset and diagnostics block.
`timescale 1ns/10ps
`include "token_net_map.svh"
module token_net_reset_init_diag_properties
   import token_net_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic hw_reset_in_n,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic nid_we,
   input wire logic diag_rd,
   input wire logic host_mode_in,
   input wire logic rx_line_in,
   input net_events_t net_ev,
   input wire logic [7:0] cfg_reg,
   input wire logic [7:0] node_identity_reg,
   input diag_flags_t diag_flags,
   input wire logic refusal_irq,
   input ram_wr_t ram_wr,
   input wire logic core_awake,
   input wire logic join_active,
   input wire logic tx_driver_en,
   input wire logic bus_mode,
   input wire logic bus_mode_known,
   input wire logic in_reset
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   chk_cfg_write: assert property
      (cfg_we && !in_reset |=> cfg_reg == $past(cfg_wdata)) else $error("config write lost");
   chk_sig_writes: assert property
      (nid_we && !in_reset |-> ##2 (ram_wr.we && ram_wr.addr == `SIG_ADDR_PATTERN
         && ram_wr.data == `SIG_PATTERN) ##1 (ram_wr.we && ram_wr.addr == `SIG_ADDR_IDENT
         && ram_wr.data == node_identity_reg)) else $error("signature writes wrong");
   chk_wake_needs_id: assert property
      ($rose(core_awake) |-> node_identity_reg != 8'h00) else $error("core woke with zero id");
   chk_join_gate: assert property
      ($rose(join_active) |-> cfg_reg[`CFG_JOIN_EN_BIT] && node_identity_reg != 8'h00)
      else $error("joined without enable");
   chk_irq_with_flag: assert property
      ($rose(refusal_irq) |-> $rose(diag_flags.refusal_limit_flag)) else $error("irq without flag");
   chk_diag_read_clear: assert property
      (diag_rd && !net_ev.response_seen && !net_ev.reshuffle_timer_expired |=>
         !diag_flags.dup_node_flag && !diag_flags.self_caused_reshuffle_flag)
      else $error("status read did not clear");
   chk_line_activity: assert property
      (rx_line_in && !in_reset && !cfg_reg[`CFG_SW_RESET_BIT] |=> diag_flags.line_activity_flag)
      else $error("activity not flagged");
   chk_own_token: assert property
      (net_ev.token_valid && net_ev.token_from_self && !diag_flags.token_seen_flag |=>
         !diag_flags.token_seen_flag) else $error("own token flagged");
   chk_tx_quiet: assert property
      (in_reset |-> !tx_driver_en) else $error("transmitter on in reset");
   chk_glitch_ignored: assert property
      (hw_reset_in_n && !in_reset ##1 !hw_reset_in_n [*4] ##1 hw_reset_in_n |-> !in_reset [*6])
      else $error("short pulse caused reset");
   chk_long_low_resets: assert property
      (!hw_reset_in_n [*8] |-> ##[0:3] in_reset) else $error("long pulse ignored");
   chk_bus_latch: assert property
      ($rose(bus_mode_known) |-> bus_mode == $past(host_mode_in)) else $error("bus mode wrong");

   cov_refusal: cover property ($rose(diag_flags.refusal_limit_flag));
   cov_dup: cover property ($rose(diag_flags.dup_node_flag));
   cov_sig: cover property (ram_wr.we && ram_wr.addr == `SIG_ADDR_IDENT);
endmodule // token_net_reset_init_diag_properties

bind token_net_reset_init_diag token_net_reset_init_diag_properties chk (
   .clock(clock), .nrst(nrst), .hw_reset_in_n(hw_reset_in_n), .cfg_we(cfg_we),
   .cfg_wdata(cfg_wdata), .nid_we(nid_we), .diag_rd(diag_rd), .host_mode_in(host_mode_in),
   .rx_line_in(rx_line_in), .net_ev(net_ev), .cfg_reg(cfg_reg),
   .node_identity_reg(node_identity_reg), .diag_flags(diag_flags), .refusal_irq(refusal_irq),
   .ram_wr(ram_wr), .core_awake(core_awake), .join_active(join_active),
   .tx_driver_en(tx_driver_en), .bus_mode(bus_mode), .bus_mode_known(bus_mode_known),
   .in_reset(in_reset)
);

// [dv/token_net_peer.sv]
// Behavioural model of the other nodes that share the network media.
`timescale 1ns/10ps
module token_net_peer
   import token_net_pkg::*;
(
   input wire logic clock,
   output net_events_t net_ev,
   output logic rx_line_in
);
   initial
   begin
      net_ev = '0;
      rx_line_in = 1'h0;
   end
   task automatic token(input logic [7:0] dest, input logic own, input logic answer);
      net_ev.token_valid = 1'h1;
      net_ev.token_dest = dest;
      net_ev.token_from_self = own;
      rx_line_in = 1'h1;
      @(posedge clock);
      #1;
      net_ev.token_valid = 1'h0;
      net_ev.token_dest = ~dest;
      net_ev.response_seen = answer;
      rx_line_in = answer;
      @(posedge clock);
      #1;
      net_ev.response_seen = 1'h0;
      rx_line_in = 1'h0;
      @(posedge clock);
      #1;
   endtask
   // Code bits: timer expiry, refusal, token arrival.
   task automatic events(input logic [2:0] code, input int n);
      repeat (n)
      begin
         {net_ev.reshuffle_timer_expired, net_ev.nak_rx, net_ev.token_rx} = code;
         @(posedge clock);
         #1;
      end
      {net_ev.reshuffle_timer_expired, net_ev.nak_rx, net_ev.token_rx} = 3'h0;
      @(posedge clock);
      #1;
   endtask
   task automatic set_next(input logic [7:0] v);
      net_ev.next_node = v;
      @(posedge clock);
      #1;
   endtask
endmodule // token_net_peer

// [dv/tb_token_net_reset_init_diag.sv]
// Self-checking bench for the reset and diagnostics block.
`timescale 1ns/10ps
`define CHK(name, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("unexpected %s: expected %h, seen %h", name, exp, got); \
      end \
   end
module tb_token_net_reset_init_diag import token_net_pkg::*;;
   logic clock, nrst, hw_reset_in_n, host_mode_in, rx_line_in;
   logic [9:0] strb;
   logic [7:0] wdata, cfg_reg, aux_setup_reg, node_identity_reg;
   net_events_t net_ev;
   diag_flags_t diag_flags;
   ram_wr_t ram_wr;
   logic refusal_irq, core_awake, join_active, tx_driver_en, bus_mode, bus_mode_known;
   logic dup_check_done, in_reset;
   int miscompares, samples_checked, lim;
   localparam int S_CFG = 0, S_AUX = 1, S_NID = 2, S_TENT = 3, S_RD = 4, S_CLR = 5;
   localparam int S_TXON = 6, S_TXOFF = 7, S_WODD = 8, S_RODD = 9;

   initial clock = 1'h0;
   always #50 clock = ~clock;

   token_net_reset_init_diag #(.DUP_WIN_SHORT_CYC(40), .DUP_WIN_LONG_CYC(80)) DUT (
      .clock(clock), .nrst(nrst), .hw_reset_in_n(hw_reset_in_n), .cfg_we(strb[S_CFG]),
      .cfg_wdata(wdata), .aux_we(strb[S_AUX]), .aux_wdata(wdata), .nid_we(strb[S_NID]),
      .nid_wdata(wdata), .tent_we(strb[S_TENT]), .tent_wdata(wdata), .diag_rd(strb[S_RD]),
      .clear_flags_cmd(strb[S_CLR]), .tx_enable_cmd(strb[S_TXON]),
      .tx_disable_cmd(strb[S_TXOFF]), .host_wr_odd(strb[S_WODD]), .host_rd_odd(strb[S_RODD]),
      .host_mode_in(host_mode_in), .rx_line_in(rx_line_in), .net_ev(net_ev),
      .cfg_reg(cfg_reg), .aux_setup_reg(aux_setup_reg), .node_identity_reg(node_identity_reg),
      .diag_flags(diag_flags), .refusal_irq(refusal_irq), .ram_wr(ram_wr),
      .core_awake(core_awake), .join_active(join_active), .tx_driver_en(tx_driver_en),
      .bus_mode(bus_mode), .bus_mode_known(bus_mode_known), .dup_check_done(dup_check_done),
      .in_reset(in_reset));

   token_net_peer PEER (.clock(clock), .net_ev(net_ev), .rx_line_in(rx_line_in));

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic pulse(input int s);
      strb[s] = 1'h1;
      tick(1);
      strb[s] = 1'h0;
      tick(1);
   endtask
   task automatic wr(input int s, input logic [7:0] d);
      wdata = d;
      pulse(s);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #2000000;
      miscompares++;
      wrap_up;
   end

   initial
   begin
      nrst = 1'h0;
      hw_reset_in_n = 1'h1;
      host_mode_in = 1'h1;
      strb = '0;
      wdata = 8'h00;
      miscompares = 0;
      samples_checked = 0;
      tick(10);
      nrst = 1'h1;
      tick(3);
      `CHK("cfg", 8'h00, cfg_reg);
      `CHK("flags", 8'h01, diag_flags);
      pulse(S_WODD);
      pulse(S_RODD);
      tick(1);
      `CHK("bus known", 1'h1, bus_mode_known);
      `CHK("bus mode", 1'h1, bus_mode);
      PEER.token(8'h2A, 1'h1, 1'h0);
      `CHK("own token", 1'h0, diag_flags.token_seen_flag);
      PEER.token(8'h2A, 1'h0, 1'h0);
      `CHK("token seen", 1'h1, diag_flags.token_seen_flag);
      `CHK("activity", 1'h1, diag_flags.line_activity_flag);
      `CHK("dormant", 1'h0, core_awake);
      wr(S_AUX, 8'h01);
      wr(S_NID, 8'h2A);
      `CHK("sig pattern", {1'h1, 11'h000, 8'hD1}, ram_wr);
      tick(1);
      `CHK("sig ident", {1'h1, 11'h001, 8'h2A}, ram_wr);
      `CHK("awake", 1'h1, core_awake);
      PEER.token(8'h2B, 1'h0, 1'h1);
      `CHK("dup", 1'h0, diag_flags.dup_node_flag);
      PEER.token(8'h2A, 1'h0, 1'h1);
      `CHK("dup", 1'h1, diag_flags.dup_node_flag);
      `CHK("window", 1'h0, dup_check_done);
      tick(80);
      `CHK("window", 1'h1, dup_check_done);
      pulse(S_RD);
      `CHK("dup read", 1'h0, diag_flags.dup_node_flag);
      wr(S_TENT, 8'h33);
      PEER.token(8'h34, 1'h0, 1'h1);
      `CHK("probe", 1'h0, diag_flags.probe_match_flag);
      PEER.token(8'h33, 1'h0, 1'h1);
      `CHK("probe", 1'h1, diag_flags.probe_match_flag);
      for (int k = 0; k < 2; k++)
      begin
         wr(S_AUX, {7'h00, k[0]});
         lim = k ? 4 : 128;
         pulse(S_CLR);
         PEER.events(3'h2, lim - 1);
         `CHK("refusal", 1'h0, diag_flags.refusal_limit_flag);
         PEER.events(3'h2, 1);
         `CHK("refusal", 1'h1, diag_flags.refusal_limit_flag);
         `CHK("irq", 1'h1, refusal_irq);
         pulse(S_CLR);
         `CHK("refusal clear", 1'h0, diag_flags.refusal_limit_flag);
         PEER.events(3'h2, lim);
         `CHK("refusal wrap", 1'h1, diag_flags.refusal_limit_flag);
      end
      PEER.set_next(8'h40);
      tick(1);
      `CHK("next node", 1'h1, diag_flags.new_next_node_flag);
      PEER.events(3'h4, 1);
      `CHK("self reshuffle", 1'h0, diag_flags.self_caused_reshuffle_flag);
      `CHK("join", 1'h0, join_active);
      wr(S_CFG, 8'h20);
      tick(2);
      `CHK("join", 1'h1, join_active);
      `CHK("tx on", 1'h1, tx_driver_en);
      PEER.events(3'h4, 1);
      `CHK("self reshuffle", 1'h1, diag_flags.self_caused_reshuffle_flag);
      pulse(S_RD);
      `CHK("self read", 1'h0, diag_flags.self_caused_reshuffle_flag);
      pulse(S_TXON);
      `CHK("tx avail", 1'h0, diag_flags.tx_available_flag);
      pulse(S_TXOFF);
      `CHK("tx avail", 1'h0, diag_flags.tx_available_flag);
      PEER.events(3'h1, 1);
      `CHK("tx avail", 1'h1, diag_flags.tx_available_flag);
      wr(S_CFG, 8'hA0);
      tick(3);
      `CHK("in reset", 1'h1, in_reset);
      `CHK("id", 8'h00, node_identity_reg);
      `CHK("cfg kept", 8'hA0, cfg_reg);
      `CHK("aux kept", 8'h01, aux_setup_reg);
      `CHK("bus kept", 1'h1, bus_mode_known);
      `CHK("tx off", 1'h0, tx_driver_en);
      wr(S_CFG, 8'h18);
      tick(3);
      `CHK("in reset", 1'h0, in_reset);
      hw_reset_in_n = 1'h0;
      tick(4);
      hw_reset_in_n = 1'h1;
      tick(8);
      `CHK("glitch", 8'h18, cfg_reg);
      hw_reset_in_n = 1'h0;
      tick(8);
      hw_reset_in_n = 1'h1;
      tick(4);
      `CHK("hw cfg", 8'h00, cfg_reg);
      `CHK("hw aux", 8'h00, aux_setup_reg);
      `CHK("hw bus", 1'h0, bus_mode_known);
      host_mode_in = 1'h0;
      pulse(S_WODD);
      pulse(S_RODD);
      `CHK("bus known", 1'h1, bus_mode_known);
      `CHK("bus mode", 1'h0, bus_mode);
      wrap_up;
   end
endmodule // tb_token_net_reset_init_diag
